// >>> core/nvme_host_map.vh
// Constants shared by the storage host controller, its checker and its bench.
// Assumes it is included by bare name from files under core/.
`ifndef NVME_HOST_MAP_VH
`define NVME_HOST_MAP_VH

// ****************************************
// Buffer sizing
// ****************************************
`define BUF_DEPTH 15'h4000
`define CHUNK_BEATS 14'h2000
`define BEATS_PER_BLOCK_SHIFT 5'h00

// ****************************************
// Packet shape
// ****************************************
`define CMD_LAST_BEAT 2'h3
`define IDEN_LAST 14'h01ff
`define CTM_LAST 14'h001f

// ****************************************
// Command codes
// ****************************************
`define OP_IDENTIFY 3'h0
`define OP_SHUTDOWN 3'h1
`define OP_WRITE 3'h2
`define OP_READ 3'h3
`define OP_SMART 3'h4
`define OP_FLUSH 3'h6

// ****************************************
// Status beat fields
// ****************************************
`define ST_CODE 15:0
`define ST_CAP 63:16
`define ST_LBADS 71:64
`define LBADS_512 8'h09
`define LBADS_4K 8'h0c

// ****************************************
// Error status bits
// ****************************************
`define ERR_SSD 0
`define ERR_BLOCK 1
`define ERR_CMD 2
`define ERR_W 3

`endif

// >>> core/pair_buffer.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module pair_buffer
(
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Filling side
	input wire [127:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// Draining side
	output wire [127:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [127:0] d0_reg;
	reg [127:0] d1_reg;
	reg v0_reg;
	reg v1_reg;
	wire push = in_valid & ~v1_reg;
	wire pop = v0_reg & out_ready;

	assign in_ready = ~v1_reg;
	assign out_data = d0_reg;
	assign out_valid = v0_reg;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			d0_reg <= 128'h0;
			d1_reg <= 128'h0;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
		end
		else if (push & ~pop)
		begin
			if (!v0_reg)
			begin
				d0_reg <= in_data;
				v0_reg <= 1'b1;
			end
			else
			begin
				d1_reg <= in_data;
				v1_reg <= 1'b1;
			end
		end
		else if (pop & ~push)
		begin
			d0_reg <= d1_reg;
			v0_reg <= v1_reg;
			v1_reg <= 1'b0;
		end
		else if (pop & push)
		begin
			if (v1_reg)
			begin
				d0_reg <= d1_reg;
				d1_reg <= in_data;
			end
			else
				d0_reg <= in_data;
		end
	end
endmodule

// >>> core/nvme_host_top.v
// Storage host controller: user command port, data buffer and 128-bit link stream.
// Assumes the link clock and link inputs come from another domain and are sampled here.
`timescale 1ns/1ps
`include "nvme_host_map.vh"

// Notes on behaviour
// RULE1 - Six commands accepted through a control group and data groups.
// RULE2 - User gives start address and length with a request for Write and Read.
// RULE3 - Write and Read payload moves over a valid/ready FIFO-style port.
// RULE4 - SMART and Flush use the custom command words; only SMART data goes out on a custom RAM port.
// RULE5 - Identify data leaves through its own RAM write port.
// RULE6 - A 256 KB internal RAM buffers Write and Read data.
// RULE7 - Attached drive uses 4 KB minimum pages and 128 KB or unlimited transfers.
// RULE8 - Only 512-byte or 4096-byte logical blocks; others raise an error.
// RULE9 - Attached device carries mass-storage, non-volatile, host-interface class codes.
// RULE10 - Abnormal conditions raise an error output with a cause status.
// RULE11 - Error status clears only by reset of controller and drive.
// RULE12 - Transmit packets have valid data every beat from start to end.
// RULE13 - User clock must run at or above the link clock; the code samples the link clock on the user clock, so equal rates fail.
// RULE14 - Link data path is 128 bits wide toward a four-lane link block.
// RULE15 - One controller serves one drive directly, no switch.
// RULE16 - User issues Identify first to learn capacity and block size.
// RULE17 - After Shutdown the controller refuses all commands until reset.
module nvme_host_top
(
	// Clock and reset
	input wire CORE_CLK,
	input wire NRST,
	// Command control
	input wire [2:0] USER_COMMAND_CODE,
	input wire USER_REQ,
	input wire [47:0] USER_ADDR,
	input wire [31:0] USER_LEN,
	output reg USER_BUSY,
	input wire [511:0] CTM_SUBM,
	// Write data in
	input wire [127:0] W_DATA,
	input wire W_VALID,
	output reg W_READY,
	// Read data out
	output wire [127:0] R_DATA,
	output wire R_VALID,
	input wire R_READY,
	// Identify RAM port
	output reg IDEN_WE,
	output reg [8:0] IDEN_ADDR,
	output reg [127:0] IDEN_DATA,
	// Custom RAM port
	output reg CTM_WE,
	output reg [4:0] CTM_ADDR,
	output reg [127:0] CTM_DATA,
	// Drive facts and errors
	output reg [47:0] DISK_CAPACITY_BLOCKS,
	output reg BLOCK_SIZE_SELECT,
	output reg ERROR,
	output reg [`ERR_W-1:0] ERROR_CODE,
	// Link
	input wire LINK_CLK,
	input wire LINKUP,
	output reg [127:0] TX_DATA,
	output reg TX_VALID,
	output reg TX_SOP,
	output reg TX_EOP,
	input wire [127:0] RX_DATA,
	input wire RX_VALID
);
	localparam S_LINK = 4'h0;
	localparam S_IDLE = 4'h1;
	localparam S_WAIT = 4'h2;
	localparam S_TXC = 4'h3;
	localparam S_TXD = 4'h4;
	localparam S_RESP = 4'h5;
	localparam S_RXD = 4'h6;
	localparam S_DRAIN = 4'h7;
	localparam S_HALT = 4'h8;

	reg [3:0] state_reg;
	reg [2:0] cmd_reg;
	reg [47:0] addr_reg;
	reg [36:0] cmd_rem_reg;
	reg [36:0] user_rem_reg;
	reg [13:0] chunk_reg;
	reg [13:0] cnt_reg;
	reg [1:0] beat_reg;
	reg [14:0] fill_reg;
	reg [13:0] wr_ptr_reg;
	reg [13:0] rd_ptr_reg;
	reg rd_pend_reg;
	reg avail_reg;
	reg stage_valid_reg;
	reg [127:0] stage_data_reg;
	reg [127:0] mem_q;
	reg [127:0] buf_mem [0:16383]; // [RULE6]
	reg lclk_s1, lclk_s2, lclk_s3;
	reg up_s1, up_s2;
	reg rxv_s1, rxv_s2;
	reg [127:0] rx_s1, rx_s2;
	reg [`ERR_W-1:0] err_set;
	reg [127:0] cmd_beat;

	// ****************************************
	// Link sampling
	// ****************************************
	// Receive data is taken half a link period after the far end changes it.
	wire rise_tick = lclk_s2 & ~lclk_s3;
	wire fall_tick = ~lclk_s2 & lclk_s3;
	wire rx_take = fall_tick & rxv_s2;

	always @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lclk_s1 <= 1'b0;
			lclk_s2 <= 1'b0;
			lclk_s3 <= 1'b0;
			up_s1 <= 1'b0;
			up_s2 <= 1'b0;
			rxv_s1 <= 1'b0;
			rxv_s2 <= 1'b0;
			rx_s1 <= 128'h0;
			rx_s2 <= 128'h0;
		end
		else
		begin
			lclk_s1 <= LINK_CLK;
			lclk_s2 <= lclk_s1;
			lclk_s3 <= lclk_s2;
			up_s1 <= LINKUP; // [RULE15]
			up_s2 <= up_s1;
			rxv_s1 <= RX_VALID;
			rxv_s2 <= rxv_s1;
			rx_s1 <= RX_DATA;
			rx_s2 <= rx_s1;
		end
	end

	// ****************************************
	// Buffer paths
	// ****************************************
	wire write_cmd = (cmd_reg == `OP_WRITE);
	wire read_cmd = (cmd_reg == `OP_READ);
	wire active = (state_reg != S_IDLE) & (state_reg != S_LINK) & (state_reg != S_HALT);
	wire w_take = W_VALID & W_READY; // [RULE3]
	wire rx_store = (state_reg == S_RXD) & rx_take & read_cmd;
	wire mem_we = w_take | rx_store;
	wire tx_pull = (state_reg == S_TXD) & rise_tick;
	wire buf_in_ready;
	// One beat per two cycles toward the user: the RAM read is registered and
	// the pointer must settle before the next word is taken. A word written on
	// one edge reaches the read register only on the next, hence the wait on avail_reg.
	wire stage_load = read_cmd & (fill_reg != 15'h0) & avail_reg & ~rd_pend_reg &
		(~stage_valid_reg | buf_in_ready);
	wire [14:0] fill_next = fill_reg + {14'h0, mem_we} - {14'h0, tx_pull} - {14'h0, stage_load};
	wire [36:0] user_rem_next = user_rem_reg - {36'h0, w_take};
	wire [13:0] chunk_sel = (cmd_rem_reg > {23'h0, `CHUNK_BEATS}) ? `CHUNK_BEATS :
		cmd_rem_reg[13:0];
	wire [14:0] free_space = `BUF_DEPTH - fill_reg;
	wire [13:0] rx_last = (cmd_reg == `OP_IDENTIFY) ? `IDEN_LAST :
		(cmd_reg == `OP_SMART) ? `CTM_LAST : chunk_reg - 14'h1;

	always @(posedge CORE_CLK)
	begin
		if (mem_we)
			buf_mem[wr_ptr_reg] <= w_take ? W_DATA : rx_s2;
		mem_q <= buf_mem[rd_ptr_reg];
	end

	pair_buffer u_out_buf
	(
		.clk(CORE_CLK),
		.nrst(NRST),
		.in_data(stage_data_reg),
		.in_valid(stage_valid_reg),
		.in_ready(buf_in_ready),
		.out_data(R_DATA),
		.out_valid(R_VALID),
		.out_ready(R_READY)
	);

	// ****************************************
	// Command beats
	// ****************************************
	always @*
	begin
		cmd_beat = 128'h0;
		if ((cmd_reg == `OP_SMART) | (cmd_reg == `OP_FLUSH))
			cmd_beat = CTM_SUBM[beat_reg*128 +: 128]; // [RULE4]
		else if (beat_reg == 2'h0)
			cmd_beat = {18'h0, chunk_reg, addr_reg, 45'h0, cmd_reg};
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always @*
	begin
		err_set = {`ERR_W{1'b0}};
		if ((state_reg == S_IDLE) & USER_REQ & ((USER_COMMAND_CODE == 3'h5) |
			(USER_COMMAND_CODE == 3'h7)))
			err_set[`ERR_CMD] = 1'b1; // [RULE10]
		if ((state_reg == S_RESP) & rx_take & (rx_s2[`ST_CODE] != 16'h0))
			err_set[`ERR_SSD] = 1'b1; // [RULE10]
		if ((state_reg == S_RESP) & rx_take & (cmd_reg == `OP_IDENTIFY) &
			(rx_s2[`ST_LBADS] != `LBADS_512) & (rx_s2[`ST_LBADS] != `LBADS_4K))
			err_set[`ERR_BLOCK] = 1'b1; // [RULE8]
	end

	always @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_reg <= S_LINK;
			cmd_reg <= `OP_IDENTIFY;
			addr_reg <= 48'h0;
			cmd_rem_reg <= 37'h0;
			user_rem_reg <= 37'h0;
			chunk_reg <= 14'h0;
			cnt_reg <= 14'h0;
			beat_reg <= 2'h0;
			fill_reg <= 15'h0;
			wr_ptr_reg <= 14'h0;
			rd_ptr_reg <= 14'h0;
			rd_pend_reg <= 1'b0;
			avail_reg <= 1'b0;
			stage_valid_reg <= 1'b0;
			stage_data_reg <= 128'h0;
			USER_BUSY <= 1'b1;
			W_READY <= 1'b0;
			IDEN_WE <= 1'b0;
			IDEN_ADDR <= 9'h0;
			IDEN_DATA <= 128'h0;
			CTM_WE <= 1'b0;
			CTM_ADDR <= 5'h0;
			CTM_DATA <= 128'h0;
			DISK_CAPACITY_BLOCKS <= 48'h0;
			BLOCK_SIZE_SELECT <= 1'b0;
			ERROR <= 1'b0;
			ERROR_CODE <= {`ERR_W{1'b0}};
			TX_DATA <= 128'h0;
			TX_VALID <= 1'b0;
			TX_SOP <= 1'b0;
			TX_EOP <= 1'b0;
		end
		else
		begin
			fill_reg <= fill_next;
			user_rem_reg <= user_rem_next;
			W_READY <= write_cmd & active & (user_rem_next != 37'h0) & (fill_next < `BUF_DEPTH);
			if (mem_we)
				wr_ptr_reg <= wr_ptr_reg + 14'h1;
			if (tx_pull | stage_load)
				rd_ptr_reg <= rd_ptr_reg + 14'h1;
			rd_pend_reg <= stage_load;
			avail_reg <= (fill_reg != 15'h0);
			if (stage_load)
			begin
				stage_data_reg <= mem_q;
				stage_valid_reg <= 1'b1;
			end
			else if (stage_valid_reg & buf_in_ready)
				stage_valid_reg <= 1'b0;
			// Only reset clears the cause bits; a new cause just adds to them.
			ERROR_CODE <= ERROR_CODE | err_set; // [RULE11]
			ERROR <= (|ERROR_CODE) | (|err_set); // [RULE10]
			IDEN_WE <= 1'b0;
			CTM_WE <= 1'b0;
			if (rise_tick)
			begin
				TX_VALID <= 1'b0;
				TX_SOP <= 1'b0;
				TX_EOP <= 1'b0;
			end
			USER_BUSY <= (state_reg != S_IDLE);
			case (state_reg)
				S_LINK:
				begin
					if (up_s2)
						state_reg <= S_IDLE;
				end
				S_IDLE:
				begin
					if (USER_REQ & (err_set == {`ERR_W{1'b0}})) // [RULE1]
					begin
						cmd_reg <= USER_COMMAND_CODE;
						addr_reg <= USER_ADDR; // [RULE2]
						cmd_rem_reg <= {USER_LEN, `BEATS_PER_BLOCK_SHIFT};
						user_rem_reg <= (USER_COMMAND_CODE == `OP_WRITE) ?
							{USER_LEN, `BEATS_PER_BLOCK_SHIFT} : 37'h0;
						chunk_reg <= 14'h0;
						beat_reg <= 2'h0;
						USER_BUSY <= 1'b1;
						if ((USER_COMMAND_CODE == `OP_WRITE) | (USER_COMMAND_CODE == `OP_READ))
							state_reg <= S_WAIT;
						else
							state_reg <= S_TXC;
					end
				end
				S_WAIT:
				begin
					if (cmd_rem_reg == 37'h0)
						state_reg <= read_cmd ? S_DRAIN : S_IDLE;
					else if (write_cmd ? (fill_reg >= {1'b0, chunk_sel}) :
						(free_space >= {1'b0, chunk_sel}))
					begin
						chunk_reg <= chunk_sel;
						beat_reg <= 2'h0;
						state_reg <= S_TXC;
					end
				end
				S_TXC:
				begin
					// Data beats follow command beats on consecutive link edges.
					if (rise_tick) // [RULE12] [RULE14]
					begin
						TX_DATA <= cmd_beat;
						TX_VALID <= 1'b1;
						TX_SOP <= (beat_reg == 2'h0);
						TX_EOP <= (beat_reg == `CMD_LAST_BEAT) & ~write_cmd;
						beat_reg <= beat_reg + 2'h1;
						cnt_reg <= chunk_reg;
						if (beat_reg == `CMD_LAST_BEAT)
							state_reg <= write_cmd ? S_TXD : S_RESP;
					end
				end
				S_TXD:
				begin
					if (rise_tick) // [RULE12]
					begin
						TX_DATA <= mem_q;
						TX_VALID <= 1'b1;
						TX_EOP <= (cnt_reg == 14'h1);
						cnt_reg <= cnt_reg - 14'h1;
						if (cnt_reg == 14'h1)
							state_reg <= S_RESP;
					end
				end
				S_RESP:
				begin
					if (rx_take)
					begin
						cnt_reg <= 14'h0;
						if (err_set != {`ERR_W{1'b0}})
							state_reg <= S_HALT;
						else if (cmd_reg == `OP_IDENTIFY)
						begin
							DISK_CAPACITY_BLOCKS <= rx_s2[`ST_CAP];
							BLOCK_SIZE_SELECT <= (rx_s2[`ST_LBADS] == `LBADS_4K); // [RULE8]
							state_reg <= S_RXD;
						end
						else if ((cmd_reg == `OP_SMART) | read_cmd)
							state_reg <= S_RXD;
						else if (write_cmd)
						begin
							cmd_rem_reg <= cmd_rem_reg - {23'h0, chunk_reg};
							addr_reg <= addr_reg + {39'h0, chunk_reg[13:5]};
							state_reg <= S_WAIT;
						end
						else if (cmd_reg == `OP_SHUTDOWN)
							state_reg <= S_HALT; // [RULE17]
						else
							state_reg <= S_IDLE;
					end
				end
				S_RXD:
				begin
					if (rx_take)
					begin
						cnt_reg <= cnt_reg + 14'h1;
						if (cmd_reg == `OP_IDENTIFY)
						begin
							IDEN_WE <= 1'b1; // [RULE5]
							IDEN_ADDR <= cnt_reg[8:0];
							IDEN_DATA <= rx_s2;
						end
						else if (cmd_reg == `OP_SMART)
						begin
							CTM_WE <= 1'b1; // [RULE4]
							CTM_ADDR <= cnt_reg[4:0];
							CTM_DATA <= rx_s2;
						end
						if (cnt_reg == rx_last)
						begin
							if (read_cmd)
							begin
								cmd_rem_reg <= cmd_rem_reg - {23'h0, chunk_reg};
								addr_reg <= addr_reg + {39'h0, chunk_reg[13:5]};
								state_reg <= S_WAIT;
							end
							else
								state_reg <= S_IDLE;
						end
					end
				end
				S_DRAIN:
				begin
					if ((fill_reg == 15'h0) & ~stage_valid_reg & ~rd_pend_reg & ~R_VALID)
						state_reg <= S_IDLE;
				end
				S_HALT:
				begin
					USER_BUSY <= 1'b1; // [RULE17]
				end
				default:
				begin
					state_reg <= S_HALT;
				end
			endcase
		end
	end
endmodule

// >>> test/host_chk_assertions.sv
// Concurrent checks on the storage host controller top.
// Assumes it is bound to nvme_host_top and sees only its ports.
`timescale 1ns/1ps
`include "nvme_host_map.vh"

module host_chk
(
	// Core side
	input wire CORE_CLK,
	input wire NRST,
	input wire [2:0] USER_COMMAND_CODE,
	input wire USER_REQ,
	input wire USER_BUSY,
	input wire W_READY,
	input wire [127:0] R_DATA,
	input wire R_VALID,
	input wire R_READY,
	input wire IDEN_WE,
	input wire [8:0] IDEN_ADDR,
	input wire CTM_WE,
	input wire ERROR,
	input wire [`ERR_W-1:0] ERROR_CODE,
	// Link side
	input wire TX_VALID,
	input wire TX_SOP,
	input wire TX_EOP
);
	// ********
	// Helpers
	// ********
	reg shut_reg;
	reg [8:0] iden_prev_reg;
	wire take = USER_REQ && !USER_BUSY;
	wire bad = USER_COMMAND_CODE == 3'h5 || USER_COMMAND_CODE == 3'h7;

	always @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			shut_reg <= 1'b0;
			iden_prev_reg <= 9'h000;
		end
		else
		begin
			shut_reg <= shut_reg | (take && USER_COMMAND_CODE == 3'h1);
			if (IDEN_WE)
				iden_prev_reg <= IDEN_ADDR;
		end
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	a_req_busy: assert property (take && !bad |=> USER_BUSY)
		else $error("legal request did not raise busy");
	a_bad_code: assert property (take && bad |=> ERROR && ERROR_CODE[`ERR_CMD])
		else $error("illegal code not flagged");
	a_err_cause: assert property (ERROR |-> ERROR_CODE != 0 &&
		(USER_BUSY || !ERROR_CODE[`ERR_SSD] && !ERROR_CODE[`ERR_BLOCK]))
		else $error("error without cause or not halted");
	a_err_sticky: assert property (ERROR |=> ERROR &&
		(ERROR_CODE & $past(ERROR_CODE)) == $past(ERROR_CODE))
		else $error("error status cleared without reset");
	a_shut_halt: assert property (shut_reg |-> USER_BUSY)
		else $error("controller idle after shutdown");
	a_tx_nogap: assert property (TX_VALID && !TX_EOP |=> TX_VALID)
		else $error("gap inside transmit packet");
	a_sop_valid: assert property (TX_SOP |-> TX_VALID)
		else $error("start of packet without valid");
	a_iden_order: assert property (IDEN_WE && IDEN_ADDR != 0 |->
		IDEN_ADDR == iden_prev_reg + 9'h001)
		else $error("identify address out of order");
	a_ram_split: assert property (IDEN_WE |-> !CTM_WE)
		else $error("identify and custom ports written together");
	a_wr_busy: assert property (W_READY |-> USER_BUSY)
		else $error("write ready outside a command");
	a_rd_hold: assert property (R_VALID && !R_READY |=> R_VALID && $stable(R_DATA))
		else $error("read beat dropped while stalled");

	c_write: cover property (take && USER_COMMAND_CODE == 3'h2);
	c_read_beat: cover property (R_VALID && R_READY);
	c_error: cover property ($rose(ERROR));
endmodule

bind nvme_host_top host_chk chk
(
	.CORE_CLK(CORE_CLK), .NRST(NRST), .USER_COMMAND_CODE(USER_COMMAND_CODE),
	.USER_REQ(USER_REQ), .USER_BUSY(USER_BUSY), .W_READY(W_READY), .R_DATA(R_DATA),
	.R_VALID(R_VALID), .R_READY(R_READY), .IDEN_WE(IDEN_WE), .IDEN_ADDR(IDEN_ADDR),
	.CTM_WE(CTM_WE), .ERROR(ERROR), .ERROR_CODE(ERROR_CODE), .TX_VALID(TX_VALID),
	.TX_SOP(TX_SOP), .TX_EOP(TX_EOP)
);

// >>> test/link_far.sv
// Behavioural far end of the link: takes packets, answers status and data.
// Assumes a free-running link clock made by the bench.
`timescale 1ns/1ps

module link_far
(
	// Link clock
	input wire link_clk,
	// From controller
	input wire [127:0] tx_data,
	input wire tx_valid,
	input wire tx_sop,
	input wire tx_eop,
	// Answer shaping
	input wire [15:0] status,
	input wire [7:0] lba_exp,
	input wire [47:0] cap,
	input wire [7:0] lag,
	// To controller
	output reg [127:0] rx_data = 128'h0,
	output reg rx_valid = 1'b0
);
	// ********
	// Model
	// ********
	// Only drives of this class are served; no configuration path reads it here.
	localparam [23:0] CLASS_CODE = 24'h010802;
	reg [127:0] beat0;
	reg [127:0] wbuf [0:31];
	integer n = 0;
	integer k = 0;
	integer cnt = 0;
	reg act = 1'b0;

	always @(posedge link_clk)
	begin
		if (tx_valid)
		begin
			if (tx_sop)
				n = 0;
			if (n == 0)
				beat0 = tx_data;
			if (n > 3 && n < 36)
				wbuf[n - 4] = tx_data;
			n = n + 1;
		end
		if (act && k >= 0)
		begin
			rx_valid <= 1'b1;
			rx_data <= (k == 0) ? {56'h0, lba_exp, cap, status} : {8{k[15:0] - 16'h1}};
		end
		else
		begin
			// An idle bus flips its word each link cycle, so the controller cannot lean on it.
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
		end
		if (act)
			k = k + 1;
		if (act && k > cnt)
			act = 1'b0;
		if (tx_valid && tx_eop)
		begin
			act = 1'b1;
			k = 0 - lag;
			case (beat0[2:0])
				3'h0: cnt = 512;
				3'h3: cnt = beat0[109:96];
				3'h4: cnt = 32;
				default: cnt = 0;
			endcase
		end
	end
endmodule

// >>> test/tb_nvme_host_user_interface.sv
// Self-checking bench for the storage host controller top.
// Assumes the far end model and the bound checker compile beside it.
`timescale 1ns/1ps
`include "nvme_host_map.vh"

module tb_nvme_host_user_interface;
	logic CORE_CLK, NRST, USER_REQ, W_VALID, R_READY, LINK_CLK, LINKUP, RX_VALID;
	logic USER_BUSY, W_READY, R_VALID, IDEN_WE, CTM_WE, BLOCK_SIZE_SELECT, ERROR;
	logic TX_VALID, TX_SOP, TX_EOP;
	logic [2:0] USER_COMMAND_CODE;
	logic [`ERR_W-1:0] ERROR_CODE;
	logic [47:0] USER_ADDR, DISK_CAPACITY_BLOCKS, cap, adr;
	logic [31:0] USER_LEN;
	logic [511:0] CTM_SUBM;
	logic [127:0] W_DATA, R_DATA, IDEN_DATA, CTM_DATA, TX_DATA, RX_DATA, iden_last, ctm_last;
	logic [127:0] wd [0:31];
	logic [8:0] IDEN_ADDR;
	logic [4:0] CTM_ADDR;
	logic [15:0] st, junk;
	logic [7:0] ex, lag;
	integer err_total = 0, tests_run = 0, cyc_n = 0, iden_n = 0, ctm_n = 0, i;

	nvme_host_top uut
	(
		.CORE_CLK(CORE_CLK), .NRST(NRST), .USER_COMMAND_CODE(USER_COMMAND_CODE),
		.USER_REQ(USER_REQ), .USER_ADDR(USER_ADDR), .USER_LEN(USER_LEN),
		.USER_BUSY(USER_BUSY), .CTM_SUBM(CTM_SUBM), .W_DATA(W_DATA), .W_VALID(W_VALID),
		.W_READY(W_READY), .R_DATA(R_DATA), .R_VALID(R_VALID), .R_READY(R_READY),
		.IDEN_WE(IDEN_WE), .IDEN_ADDR(IDEN_ADDR), .IDEN_DATA(IDEN_DATA), .CTM_WE(CTM_WE),
		.CTM_ADDR(CTM_ADDR), .CTM_DATA(CTM_DATA), .DISK_CAPACITY_BLOCKS(DISK_CAPACITY_BLOCKS),
		.BLOCK_SIZE_SELECT(BLOCK_SIZE_SELECT), .ERROR(ERROR), .ERROR_CODE(ERROR_CODE),
		.LINK_CLK(LINK_CLK), .LINKUP(LINKUP), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
		.TX_SOP(TX_SOP), .TX_EOP(TX_EOP), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID)
	);
	link_far far
	(
		.link_clk(LINK_CLK), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_sop(TX_SOP),
		.tx_eop(TX_EOP), .status(st), .lba_exp(ex), .cap(cap), .lag(lag),
		.rx_data(RX_DATA), .rx_valid(RX_VALID)
	);

	// ********
	// Clocks, helpers and tasks
	// ********
	// The core clock runs well above the link clock so transmit beats never starve.
	initial
	begin
		CORE_CLK = 0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	initial
	begin
		LINK_CLK = 0;
		#3;
		forever #40 LINK_CLK = ~LINK_CLK;
	end

	function [127:0] pat(input integer n);
		pat = {8{n[15:0]}};
	endfunction

	task summarize;
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cyc;
		@(posedge CORE_CLK);
		#1;
	endtask
	task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wait_idle;
		while (USER_BUSY !== 1'b0)
			cyc;
	endtask
	task cmd(input logic [2:0] c, input logic [47:0] a);
		wait_idle;
		USER_COMMAND_CODE = c;
		USER_ADDR = a;
		USER_REQ = 1;
		cyc;
		USER_REQ = 0;
	endtask
	task rst;
		NRST = 0;
		repeat (4) cyc;
		chk("busy in reset", 1, USER_BUSY);
		NRST = 1;
	endtask
	task feed;
		integer j;
		for (j = 0; j < 32; j++)
		begin
			W_DATA = wd[j];
			W_VALID = 1;
			while (W_READY !== 1'b1)
				cyc;
			cyc;
			if ($urandom_range(1, 0))
			begin
				W_VALID = 0;
				cyc;
			end
		end
		W_VALID = 0;
	endtask
	task drain;
		integer j;
		j = 0;
		while (j < 32)
		begin
			R_READY = $urandom_range(1, 0);
			if (R_READY && R_VALID === 1'b1)
			begin
				chk("read data", pat(j), R_DATA);
				j++;
			end
			cyc;
		end
		R_READY = 0;
	endtask

	always @(posedge CORE_CLK)
	begin
		cyc_n++;
		if (IDEN_WE === 1'b1)
			iden_n++;
		if (IDEN_WE === 1'b1 && IDEN_ADDR === 9'h1ff)
			iden_last = IDEN_DATA;
		if (CTM_WE === 1'b1)
			ctm_n++;
		if (CTM_WE === 1'b1 && CTM_ADDR === 5'h1f)
			ctm_last = CTM_DATA;
		if (cyc_n == 50000)
		begin
			err_total++;
			summarize;
		end
	end

	// ********
	// Main sequence
	// ********
	initial
	begin
		{NRST, USER_REQ, W_VALID, R_READY, LINKUP} = 5'h00;
		{USER_COMMAND_CODE, USER_ADDR, CTM_SUBM, W_DATA} = 0;
		USER_LEN = 32'h1;
		{ex, lag} = {8'h09, 8'h00};
		void'($urandom(79008));
		{cap, st} = {$urandom(), $urandom()};
		st = 0;
		rst;
		repeat (5) cyc;
		chk("busy before link", 1, USER_BUSY);
		LINKUP = 1;
		for (i = 0; i < 2; i++)
		begin
			ex = i ? 8'h0c : 8'h09;
			iden_n = 0;
			cmd(`OP_IDENTIFY, 48'h0);
			wait_idle;
			chk("capacity", cap, DISK_CAPACITY_BLOCKS);
			chk("block size", i, BLOCK_SIZE_SELECT);
			chk("identify beats", 512, iden_n);
			chk("identify last", pat(511), iden_last);
		end
		{adr, junk} = {$urandom(), $urandom()};
		for (i = 0; i < 32; i++)
			wd[i] = {$urandom(), $urandom(), $urandom(), $urandom()};
		fork
			cmd(`OP_WRITE, adr);
			feed;
		join
		wait_idle;
		chk("write command", {18'h0, 14'h0020, adr, 45'h0, 3'h2}, far.beat0);
		for (i = 0; i < 32; i++)
			chk("write data", wd[i], far.wbuf[i]);
		lag = $urandom_range(30, 0);
		{adr, junk} = {$urandom(), $urandom()};
		fork
			cmd(`OP_READ, adr);
			drain;
		join
		wait_idle;
		chk("read command", {18'h0, 14'h0020, adr, 45'h0, 3'h3}, far.beat0);
		chk("buffer empty", 0, R_VALID);
		for (i = 0; i < 2; i++)
		begin
			CTM_SUBM = {16{$urandom()}};
			CTM_SUBM[2:0] = i ? 3'h6 : 3'h4;
			ctm_n = 0;
			cmd(i ? `OP_FLUSH : `OP_SMART, 48'h0);
			wait_idle;
			chk("custom command", CTM_SUBM[127:0], far.beat0);
			chk("custom beats", i ? 0 : 32, ctm_n);
		end
		chk("custom last", pat(31), ctm_last);
		cmd(`OP_SHUTDOWN, 48'h0);
		cyc;
		USER_COMMAND_CODE = `OP_READ;
		USER_REQ = 1;
		repeat (400) cyc;
		USER_REQ = 0;
		chk("busy after shutdown", 1, USER_BUSY);
		chk("no error", 0, ERROR);
		for (i = 0; i < 3; i++)
		begin
			rst;
			st = (i == 0) ? 16'h0002 : 16'h0000;
			ex = (i == 1) ? 8'h0a : 8'h09;
			cmd((i == 2) ? ($urandom_range(1, 0) ? 3'h7 : 3'h5) : `OP_IDENTIFY, 48'h0);
			repeat (4500) cyc;
			chk("error flag", 1, ERROR);
			chk("error cause", 3'h1 << i, ERROR_CODE);
		end
		{st, ex} = {16'h0000, 8'h09};
		rst;
		wait_idle;
		chk("error cleared", 0, {ERROR, ERROR_CODE});
		summarize;
	end
endmodule
